// ==== shared/ovd_pkg.sv ====
// Purpose: constants and types for the overtravel / direction control block
// Assumes: 125 MHz system clock, APB register access with 32-bit data
// Notes: register offsets are byte addresses of aligned words
`default_nettype none
package ovd_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [11:0] REG_CONFIG = 12'h000;
    localparam logic [11:0] REG_ESTOP_TORQUE = 12'h004;
    localparam logic [11:0] REG_CTRL = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h010;
    localparam logic [11:0] REG_IRQ_MASK = 12'h014;
    localparam logic [11:0] REG_ACTIVE_CONFIG = 12'h018;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_FWD_LSB = 4;
    localparam int CFG_REV_LSB = 8;
    localparam int CFG_STOP0_LSB = 12;
    localparam int CFG_STOP1_LSB = 16;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int IRQ_FWD_OT = 0;
    localparam int IRQ_REV_OT = 1;
    localparam int IRQ_STOP_DONE = 2;

    // ---------------------------------------------------------------
    // setting codes and reset values
    // ---------------------------------------------------------------
    localparam logic DIR_RESET = 1'h0;
    localparam logic [3:0] FWD_MAP_PIN = 4'h1;
    localparam logic [3:0] REV_MAP_PIN = 4'h2;
    localparam logic [3:0] MAP_IGNORE = 4'h8;
    localparam logic [3:0] STOP0_DB_A = 4'h0;
    localparam logic [3:0] STOP0_COAST = 4'h2;
    localparam logic [3:0] STOP1_NONE = 4'h0;
    localparam logic [3:0] STOP1_CLAMP = 4'h1;
    localparam logic [9:0] ESTOP_TQ_MAX = 10'h320;
    localparam logic [9:0] TQ_FULL = 10'h320;
    localparam logic [15:0] ZERO_SPEED = 16'h0010;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int ENC_STEP_NS = 1000;
    localparam logic [7:0] ENC_DIV_LAST =
        8'(ENC_STEP_NS / CLK_PERIOD_NS - 1);

    // ---------------------------------------------------------------
    // stop sequence states
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_DB = 6'h02,
        ST_COAST_STOP = 6'h04,
        ST_DECEL = 6'h08,
        ST_ZCLAMP = 6'h10,
        ST_COAST = 6'h20
    } ovd_state_t;

endpackage
`default_nettype wire

// ==== hw/ovd_top.sv ====
// Purpose: motor direction, encoder emulation and overtravel stop control
// Assumes: all inputs synchronous to sys_clk; references signed
// Notes: direction, mapping and stop settings take effect only at reset release or a restart write
//
// Behaviour
// RULE_01: direction-select 1 reverses motor turning for a reference sign.
// RULE_02: direction-select never changes emulated encoder output polarity.
// RULE_03: forward reference makes phase B lead; reverse makes phase A lead.
// RULE_04: forward limit ON allows forward; OFF blocks it, flags overtravel.
// RULE_05: reverse limit ON allows reverse; OFF blocks it, flags overtravel.
// RULE_06: during overtravel a reference away from the limit still runs.
// RULE_07: forward mapping 1 reads the pin; mapping 8 always permits forward.
// RULE_08: reverse mapping 2 reads the pin; mapping 8 always permits reverse.
// RULE_09: stop code 00 or 01 brakes dynamically then coasts.
// RULE_10: stop code 02 removes drive, coasts to stop, stays coasting.
// RULE_11: second digit 1 decelerates at emergency torque then zero clamps.
// RULE_12: second digit 2 decelerates at emergency torque then coasts.
// RULE_13: zero clamp holds the stopped position with a position loop.
// RULE_14: torque control never decelerates; uses lowest digit, then coasts.
// RULE_15: emergency torque 0 to 800 percent, default 800, applies at once.
// RULE_16: direction, mapping and stop settings are sampled only at restart.
`timescale 1ns/1ns
`default_nettype none
module ovd_top
    import ovd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] ref_speed,
    input wire logic signed [15:0] motor_speed,
    input wire logic [15:0] motor_position,
    input wire logic torque_control,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    output logic signed [15:0] motor_cmd,
    output logic drive_enable,
    output logic dynamic_brake,
    output logic [9:0] torque_limit,
    output logic zero_clamp_active,
    output logic forward_overtravel,
    output logic reverse_overtravel,
    output logic encoder_out_phase_a,
    output logic encoder_out_phase_b,
    output logic irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        ovd_state_t state;
        logic dir_stg;
        logic [3:0] fwd_map_stg;
        logic [3:0] rev_map_stg;
        logic [3:0] stop0_stg;
        logic [3:0] stop1_stg;
        logic act_dir;
        logic [3:0] act_fwd_map;
        logic [3:0] act_rev_map;
        logic [3:0] act_stop0;
        logic [3:0] act_stop1;
        logic [9:0] estop_tq;
        logic [2:0] irq_sts;
        logic [2:0] irq_mask;
        logic fwd_ot;
        logic rev_ot;
        logic [1:0] enc_q;
        logic [7:0] enc_div;
        logic enc_a;
        logic enc_b;
        logic [15:0] hold_pos;
        logic [15:0] motor_cmd;
        logic drive_en;
        logic dyn_brake;
        logic [9:0] tq_limit;
        logic zclamp;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ovd_regs_t;

    ovd_regs_t r;
    ovd_regs_t n;
    logic acc;
    logic wr;
    logic restart_wr;
    logic ref_fwd;
    logic ref_rev;
    logic blocked;
    logic moving;
    logic step_en;
    logic [16:0] spd_ext;
    logic [16:0] spd_abs;
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;

    always_comb begin
        n = r;
        acc = psel && penable && r.pready;
        wr = acc && pwrite;
        restart_wr = wr && (paddr == REG_CTRL) && pwdata[CTRL_RESTART_BIT];
        ref_fwd = (ref_speed > 16'sh0000);
        ref_rev = (ref_speed < 16'sh0000);
        spd_ext = {motor_speed[15], motor_speed};
        spd_abs = spd_ext[16] ? (17'h00000 - spd_ext) : spd_ext;
        moving = (spd_abs >= {1'h0, ZERO_SPEED});
        // motion is judged against the reference, not the motor frame
        // RULE_04 RULE_05 RULE_06 block toward limit
        blocked = (ref_fwd && r.fwd_ot) || (ref_rev && r.rev_ot);
        irq_clr = 3'h0;

        // ---------------------------------------------------------------
        // apb slave: zero wait states, answer in the first access cycle
        // ---------------------------------------------------------------
        n.pready = psel && !penable;
        n.pslverr = 1'h0;
        n.prdata = 32'h00000000;
        if (psel && !penable) begin
            unique case (paddr)
                REG_CONFIG: n.prdata = {12'h000, r.stop1_stg, r.stop0_stg,
                    r.rev_map_stg, r.fwd_map_stg, 3'h0, r.dir_stg};
                REG_ESTOP_TORQUE: n.prdata = {22'h0, r.estop_tq};
                REG_CTRL: n.prdata = 32'h00000000;
                REG_STATUS: n.prdata = {24'h000000, r.state,
                    r.rev_ot, r.fwd_ot};
                REG_IRQ_STATUS: n.prdata = {29'h0, r.irq_sts};
                REG_IRQ_MASK: n.prdata = {29'h0, r.irq_mask};
                REG_ACTIVE_CONFIG: n.prdata = {12'h000, r.act_stop1,
                    r.act_stop0, r.act_rev_map, r.act_fwd_map, 3'h0,
                    r.act_dir};
                default: n.pslverr = 1'h1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                REG_CONFIG: begin
                    n.dir_stg = pwdata[CFG_DIR_BIT];
                    n.fwd_map_stg = pwdata[CFG_FWD_LSB +: 4];
                    n.rev_map_stg = pwdata[CFG_REV_LSB +: 4];
                    n.stop0_stg = pwdata[CFG_STOP0_LSB +: 4];
                    n.stop1_stg = pwdata[CFG_STOP1_LSB +: 4];
                end
                // RULE_15 clamp and apply at once
                REG_ESTOP_TORQUE: begin
                    if (pwdata[9:0] > ESTOP_TQ_MAX || pwdata[31:10] != 22'h0)
                        n.estop_tq = ESTOP_TQ_MAX;
                    else
                        n.estop_tq = pwdata[9:0];
                end
                REG_IRQ_STATUS: irq_clr = pwdata[2:0];
                REG_IRQ_MASK: n.irq_mask = pwdata[2:0];
                default: ;
            endcase
        end

        // ---------------------------------------------------------------
        // limit inputs
        // ---------------------------------------------------------------
        // RULE_04 RULE_07 forward limit decode
        n.fwd_ot = (r.act_fwd_map != MAP_IGNORE) && !forward_limit_input;
        // RULE_05 RULE_08 reverse limit decode
        n.rev_ot = (r.act_rev_map != MAP_IGNORE) && !reverse_limit_input;

        // ---------------------------------------------------------------
        // stop sequence
        // ---------------------------------------------------------------
        unique case (r.state)
            ST_RUN: begin
                if (blocked && moving) begin
                    // RULE_14 torque mode skips decel
                    if (torque_control || r.act_stop1 == STOP1_NONE) begin
                        // RULE_09 RULE_10 lowest digit picks
                        if (r.act_stop0 == STOP0_COAST)
                            n.state = ST_COAST_STOP;
                        else
                            n.state = ST_DB;
                    end else begin
                        n.state = ST_DECEL;
                    end
                end
            end
            ST_DB, ST_COAST_STOP: begin
                if (!moving)
                    n.state = ST_COAST;
            end
            ST_DECEL: begin
                // RULE_11 RULE_12 after-stop mode
                if (!moving)
                    n.state = (r.act_stop1 == STOP1_CLAMP) ?
                        ST_ZCLAMP : ST_COAST;
            end
            ST_ZCLAMP, ST_COAST: begin
                // RULE_06 reference away from limit resumes
                if (!blocked)
                    n.state = ST_RUN;
            end
        endcase

        // RULE_16 settings latch only here
        if (restart_wr) begin
            n.state = ST_RUN;
            n.act_dir = r.dir_stg;
            n.act_fwd_map = r.fwd_map_stg;
            n.act_rev_map = r.rev_map_stg;
            n.act_stop0 = r.stop0_stg;
            n.act_stop1 = r.stop1_stg;
        end

        // ---------------------------------------------------------------
        // power stage outputs
        // ---------------------------------------------------------------
        n.drive_en = (n.state == ST_RUN) || (n.state == ST_DECEL) ||
            (n.state == ST_ZCLAMP);
        n.dyn_brake = (n.state == ST_DB);
        n.zclamp = (n.state == ST_ZCLAMP);
        n.tq_limit = (n.state == ST_DECEL) ? n.estop_tq : TQ_FULL;
        n.motor_cmd = 16'h0000;
        if (n.state == ST_RUN && r.state == ST_RUN && !blocked) begin
            // RULE_01 direction inversion
            n.motor_cmd = r.act_dir ? 16'(16'h0000 - ref_speed) : ref_speed;
        end
        if (n.state == ST_ZCLAMP) begin
            // RULE_13 hold stopped position
            if (r.state != ST_ZCLAMP)
                n.hold_pos = motor_position;
            else
                n.motor_cmd = 16'(r.hold_pos - motor_position);
        end

        // ---------------------------------------------------------------
        // encoder emulation follows the reference, not the motor frame
        // ---------------------------------------------------------------
        n.enc_div = (r.enc_div == ENC_DIV_LAST) ? 8'h00 : r.enc_div + 8'h01;
        step_en = (r.enc_div == ENC_DIV_LAST) && r.state == ST_RUN &&
            n.state == ST_RUN && !blocked;
        // RULE_02 RULE_03 quadrature step order
        if (step_en && ref_fwd)
            n.enc_q = r.enc_q + 2'h1;
        else if (step_en && ref_rev)
            n.enc_q = r.enc_q - 2'h1;
        n.enc_a = n.enc_q[1];
        n.enc_b = n.enc_q[1] ^ n.enc_q[0];

        // ---------------------------------------------------------------
        // interrupts: set wins over a write-one clear
        // ---------------------------------------------------------------
        irq_ev = 3'h0;
        irq_ev[IRQ_FWD_OT] = n.fwd_ot && !r.fwd_ot;
        irq_ev[IRQ_REV_OT] = n.rev_ot && !r.rev_ot;
        irq_ev[IRQ_STOP_DONE] = (r.state == ST_DB ||
            r.state == ST_COAST_STOP || r.state == ST_DECEL) &&
            (n.state == ST_COAST || n.state == ST_ZCLAMP);
        n.irq_sts = (r.irq_sts & ~irq_clr) | irq_ev;
        n.irq = |(n.irq_sts & n.irq_mask);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.state <= ST_RUN;
            r.dir_stg <= DIR_RESET;
            r.fwd_map_stg <= FWD_MAP_PIN;
            r.rev_map_stg <= REV_MAP_PIN;
            r.stop0_stg <= STOP0_DB_A;
            r.stop1_stg <= STOP1_NONE;
            r.act_dir <= DIR_RESET;
            r.act_fwd_map <= FWD_MAP_PIN;
            r.act_rev_map <= REV_MAP_PIN;
            r.act_stop0 <= STOP0_DB_A;
            r.act_stop1 <= STOP1_NONE;
            r.estop_tq <= ESTOP_TQ_MAX;
            r.tq_limit <= TQ_FULL;
            r.drive_en <= 1'h1;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign motor_cmd = r.motor_cmd;
    assign drive_enable = r.drive_en;
    assign dynamic_brake = r.dyn_brake;
    assign torque_limit = r.tq_limit;
    assign zero_clamp_active = r.zclamp;
    assign forward_overtravel = r.fwd_ot;
    assign reverse_overtravel = r.rev_ot;
    assign encoder_out_phase_a = r.enc_a;
    assign encoder_out_phase_b = r.enc_b;
    assign irq = r.irq;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_db_done;
        r.state == ST_DB && !moving && !restart_wr;
    endsequence
    sequence s_decel_done;
        r.state == ST_DECEL && !moving && !restart_wr;
    endsequence

    a_dir_invert: assert property ( // RULE_01
        (r.state == ST_RUN && n.state == ST_RUN && !blocked && r.act_dir)
        |=> r.motor_cmd == 16'(16'h0000 - $past(ref_speed)))
        else $error("reversed direction not applied");
    a_enc_fwd_lead: assert property ( // RULE_03
        (step_en && ref_fwd && r.enc_q == 2'h0)
        |=> (!r.enc_a && r.enc_b))
        else $error("phase b not leading on forward");
    a_enc_rev_lead: assert property ( // RULE_03
        (step_en && ref_rev && r.enc_q == 2'h0)
        |=> (r.enc_a && !r.enc_b))
        else $error("phase a not leading on reverse");
    a_fwd_limit_flag: assert property ( // RULE_07
        (r.act_fwd_map != MAP_IGNORE && !forward_limit_input) |=> r.fwd_ot)
        else $error("forward overtravel missed");
    a_rev_map_off: assert property ( // RULE_08
        (r.act_rev_map == MAP_IGNORE) |=> !r.rev_ot)
        else $error("ignored reverse limit flagged");
    a_db_then_coast: assert property ( // RULE_09
        s_db_done |=> (r.state == ST_COAST && !r.dyn_brake && !r.drive_en))
        else $error("brake stop did not end in coast");
    a_coast_stop: assert property ( // RULE_10
        (r.state == ST_COAST_STOP) |-> (!r.drive_en && !r.dyn_brake))
        else $error("drive present during coast stop");
    a_decel_torque: assert property ( // RULE_15
        (r.state == ST_DECEL)
        |-> (r.drive_en && r.tq_limit == r.estop_tq && r.motor_cmd == 16'h0))
        else $error("decel not at emergency torque");
    a_decel_to_clamp: assert property ( // RULE_11
        (s_decel_done ##0 (r.act_stop1 == STOP1_CLAMP))
        |=> (r.state == ST_ZCLAMP && r.zclamp))
        else $error("decel did not enter zero clamp");
    a_clamp_loop: assert property ( // RULE_13
        (r.state == ST_ZCLAMP && n.state == ST_ZCLAMP)
        |=> r.motor_cmd == 16'($past(r.hold_pos) - $past(motor_position)))
        else $error("zero clamp loop error wrong");
    a_torque_no_decel: assert property ( // RULE_14
        (torque_control && r.state == ST_RUN && !restart_wr)
        |=> r.state != ST_DECEL)
        else $error("torque mode decelerated");
    a_resume_away: assert property ( // RULE_06
        (r.state == ST_COAST && !blocked && !restart_wr) |=> r.state == ST_RUN)
        else $error("reference away from limit refused");
    a_cfg_restart: assert property ( // RULE_16
        !restart_wr |=> ($stable(r.act_dir) && $stable(r.act_stop0) &&
        $stable(r.act_stop1) && $stable(r.act_fwd_map)))
        else $error("active settings changed without restart");

endmodule
`default_nettype wire

// ==== verification/ovd_motor_model.sv ====
// Purpose: machine-side model of the motor behind the power stage
// Assumes: speed follows the command at once while the stage drives
// Notes: braking sheds speed eight times faster than coasting
`timescale 1ns/1ns
`default_nettype none
module ovd_motor_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic signed [15:0] motor_cmd,
    input wire logic drive_enable,
    input wire logic dynamic_brake,
    output logic signed [15:0] motor_speed,
    output logic [15:0] motor_position
);
    logic signed [15:0] drag;

    always_comb begin
        drag = dynamic_brake ? 16'sh0008 : 16'sh0001;
    end

    // unpowered shaft keeps turning: a stop is never instant
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_speed <= '0;
            motor_position <= '0;
        end else begin
            motor_position <= motor_position + $unsigned(motor_speed);
            if (drive_enable)
                motor_speed <= motor_cmd;
            else if (motor_speed > drag)
                motor_speed <= motor_speed - drag;
            else if (motor_speed < -drag)
                motor_speed <= motor_speed + drag;
            else
                motor_speed <= '0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/overtravel_direction_control_tb.sv ====
// Purpose: self-checking bench for the overtravel and direction block
// Assumes: design answers every apb access without wait states
// Notes: outputs are read at the clock edge, before its own updates
`timescale 1ns/1ns
`default_nettype none
module overtravel_direction_control_tb import ovd_pkg::*; ;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic signed [15:0] ref_speed = '0;
    logic signed [15:0] motor_speed, motor_cmd;
    logic [15:0] motor_position;
    logic torque_control = 1'b0;
    logic forward_limit_input = 1'b1;
    logic reverse_limit_input = 1'b1;
    logic drive_enable, dynamic_brake, zero_clamp_active, irq;
    logic [9:0] torque_limit;
    logic forward_overtravel, reverse_overtravel;
    logic encoder_out_phase_a, encoder_out_phase_b;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;

    ovd_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_speed(ref_speed),
        .motor_speed(motor_speed), .motor_position(motor_position),
        .torque_control(torque_control),
        .forward_limit_input(forward_limit_input),
        .reverse_limit_input(reverse_limit_input),
        .motor_cmd(motor_cmd), .drive_enable(drive_enable),
        .dynamic_brake(dynamic_brake), .torque_limit(torque_limit),
        .zero_clamp_active(zero_clamp_active),
        .forward_overtravel(forward_overtravel),
        .reverse_overtravel(reverse_overtravel),
        .encoder_out_phase_a(encoder_out_phase_a),
        .encoder_out_phase_b(encoder_out_phase_b), .irq(irq));

    ovd_motor_model motor_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .motor_cmd(motor_cmd), .drive_enable(drive_enable),
        .dynamic_brake(dynamic_brake), .motor_speed(motor_speed),
        .motor_position(motor_position));

    task automatic test_done;
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a hung wait costs a mismatch and ends the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // entered right after a rising edge; leaves one edge after release
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic restart(input logic [31:0] cfg);
        apb(1'b1, REG_CONFIG, cfg);
        apb(1'b1, REG_CTRL, 32'h1);
    endtask

    task automatic settle;
        ref_speed <= '0;
        forward_limit_input <= 1'b1;
        reverse_limit_input <= 1'b1;
        torque_control <= 1'b0;
        while (motor_speed !== 16'sh0000) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
    endtask

    // waits for a rising phase a; phase b then tells which one leads
    task automatic enc_chk(input logic b_lead);
        logic a0;
        a0 = 1'b1;
        while (!(a0 === 1'b0 && encoder_out_phase_a === 1'b1)) begin
            a0 = encoder_out_phase_a;
            @(posedge sys_clk);
        end
        chk("phase_b", b_lead, encoder_out_phase_b);
    endtask

    task automatic t_regs;
        apb(1'b0, REG_CONFIG, 32'h0);
        chk("config", 32'h210, rd);
        apb(1'b0, REG_ACTIVE_CONFIG, 32'h0);
        chk("active", 32'h210, rd);
        apb(1'b0, REG_ESTOP_TORQUE, 32'h0);
        chk("estop", 32'h320, rd);
        apb(1'b1, REG_ESTOP_TORQUE, 32'h384);
        apb(1'b0, REG_ESTOP_TORQUE, 32'h0);
        chk("estop_clamp", 32'h320, rd);
        apb(1'b1, REG_ESTOP_TORQUE, 32'h64);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask

    task automatic t_dir;
        ref_speed <= 16'sh00c8;
        repeat (3) @(posedge sys_clk);
        chk("cmd_fwd", 32'hc8, $unsigned(motor_cmd));
        enc_chk(1'b1);
        apb(1'b1, REG_CONFIG, 32'h211);
        chk("cmd_staged", 32'hc8, $unsigned(motor_cmd));
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("cmd_inv", 32'hff38, $unsigned(motor_cmd));
        enc_chk(1'b1);
        ref_speed <= -16'sh00c8;
        // a step launched with the old reference may still show
        repeat (2) @(posedge sys_clk);
        enc_chk(1'b0);
        settle();
        restart(32'h210);
    endtask

    task automatic t_fwd_ot;
        apb(1'b1, REG_IRQ_MASK, 32'h7);
        ref_speed <= 16'sh00c8;
        repeat (5) @(posedge sys_clk);
        forward_limit_input <= 1'b0;
        while (forward_overtravel !== 1'b1) @(posedge sys_clk);
        @(posedge sys_clk);
        chk("db_on", 32'h1, dynamic_brake);
        chk("drive_off", 32'h0, drive_enable);
        while (dynamic_brake !== 1'b0) @(posedge sys_clk);
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        chk("irq_status", 32'h5, rd);
        chk("irq_on", 32'h1, irq);
        chk("cmd_blocked", 32'h0, $unsigned(motor_cmd));
        apb(1'b1, REG_IRQ_STATUS, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk("irq_cleared", 32'h0, irq);
        ref_speed <= -16'sh00c8;
        repeat (4) @(posedge sys_clk);
        chk("cmd_away", 32'hff38, $unsigned(motor_cmd));
        apb(1'b1, REG_IRQ_MASK, 32'h0);
        settle();
    endtask

    task automatic t_map;
        for (int i = 0; i < 2; i++) begin
            restart(i ? 32'h810 : 32'h280);
            forward_limit_input <= i[0];
            reverse_limit_input <= !i[0];
            ref_speed <= i ? -16'sh00c8 : 16'sh00c8;
            repeat (4) @(posedge sys_clk);
            chk("ot_flags", 32'h0,
                {forward_overtravel, reverse_overtravel});
            chk("cmd_map", i ? 32'hff38 : 32'hc8,
                $unsigned(motor_cmd));
            settle();
        end
        restart(32'h210);
    endtask

    // one reverse trip per stop code; the last case runs torque control
    task automatic t_stops;
        logic [31:0] cfg [6] = '{32'h210, 32'h1210, 32'h2210,
            32'h10210, 32'h20210, 32'h10210};
        logic [5:0] db = 6'b100011;
        logic [5:0] drv = 6'b011000;
        logic [5:0] zcl = 6'b001000;
        for (int i = 0; i < 6; i++) begin
            restart(cfg[i]);
            torque_control <= (i == 5);
            ref_speed <= -16'sh00c8;
            repeat (5) @(posedge sys_clk);
            reverse_limit_input <= 1'b0;
            while (reverse_overtravel !== 1'b1) @(posedge sys_clk);
            @(posedge sys_clk);
            chk("brake", db[i], dynamic_brake);
            chk("drive", drv[i], drive_enable);
            chk("tq_limit", drv[i] ? 100 : 800, torque_limit);
            while (motor_speed !== 16'sh0000) @(posedge sys_clk);
            repeat (3) @(posedge sys_clk);
            apb(1'b0, REG_STATUS, 32'h0);
            chk("rev_flag", 32'h1, rd[1]);
            chk("state", zcl[i] ? ST_ZCLAMP : ST_COAST,
                rd[7:2]);
            chk("clamp", zcl[i], zero_clamp_active);
            chk("cmd_held", 32'h0, $unsigned(motor_cmd));
            chk("irq_masked", 32'h0, irq);
            apb(1'b1, REG_IRQ_STATUS, 32'h7);
            settle();
        end
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_dir();
        t_fwd_ot();
        t_map();
        t_stops();
        test_done();
    end
endmodule
`default_nettype wire
